// ==== rtl/pcdl_pkg.sv ====
package pcdl_pkg;
   // ==========================================================
   // register port
   localparam int            ADDR_W        = 5;
   localparam int            DATA_W        = 16;
   localparam logic [4:0]    REG_CTRL      = 5'h00;
   localparam logic [4:0]    REG_MODE      = 5'h11;
   localparam logic [4:0]    REG_TDR       = 5'h19;
   localparam logic [4:0]    REG_CABLE     = 5'h1a;
   localparam logic [4:0]    REG_PAIR      = 5'h1b;
   // ==========================================================
   // field positions
   localparam int            CTRL_LOOP_BIT = 14;
   localparam int            CTRL_ISO_BIT  = 10;
   localparam int            MODE_FAR_BIT  = 9;
   localparam int            PAIR_SEL_BIT  = 15;
   localparam int            PAIR_AOFF_BIT = 13;
   localparam int            TDR_EN_BIT    = 15;
   localparam int            TDR_DONE_BIT  = 14;
   localparam int            TDR_ECHO_BIT  = 13;
   localparam int            TDR_LEN_LSB   = 0;
   localparam int            TDR_LEN_W     = 8;
   localparam int            CABLE_CODE_LSB = 12;
   localparam int            CABLE_M_LSB   = 0;
   localparam int            CODE_W        = 4;
   localparam int            METER_W       = 8;
   // ==========================================================
   // timing
   localparam int            CLK_PERIOD_NS = 50;
   localparam int            TDR_PULSE_NS  = 100;
   localparam int            TDR_LISTEN_NS = 12750;
   localparam int            TDR_PULSE_CYC = (TDR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int            TDR_LISTEN_CYC = TDR_LISTEN_NS / CLK_PERIOD_NS;
   localparam int            LOOP_DEPTH    = 3;
   // ==========================================================
   // matched cable lookup, metres
   localparam logic [7:0]    CABLE_M_TABLE [0:15] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h11, 8'h1b, 8'h26,
                                                     8'h31, 8'h3b, 8'h46, 8'h51, 8'h5b, 8'h66, 8'h71, 8'h7b};
   localparam logic [3:0]    CODE_ZERO_MAX = 4'h3;
   // ==========================================================
   // types
   typedef enum logic [1:0] {
      PCDL_IDLE   = 2'b00,
      PCDL_PULSE  = 2'b01,
      PCDL_LISTEN = 2'b11,
      PCDL_DONE   = 2'b10
   } pcdl_tdr_state_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] data;
   } pcdl_sym_t;
endpackage

// ==== rtl/pcdl_len_lut.sv ====
`timescale 1ns/1ps
module pcdl_len_lut
   import pcdl_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic [CODE_W-1:0]  code,
   output logic      [METER_W-1:0] meters
);
   logic [METER_W-1:0] meters_reg;
   logic [METER_W-1:0] meters_next;

   always_comb begin
      meters_next = CABLE_M_TABLE[code];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meters_reg <= '0;
      end else begin
         meters_reg <= meters_next;
      end
   end

   assign meters = meters_reg;

   // ==========================================================
   // checks
   lut_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (code <= CODE_ZERO_MAX) |=> (meters == '0))
      else $error("short code did not map to zero metres");
   lut_top_a: assert property (@(posedge clk) disable iff (!rst_n)
      (code == 4'hf) |=> (meters == 8'h7b))
      else $error("top code did not map to longest length");
endmodule // pcdl_len_lut

// ==== rtl/pcdl_top.sv ====
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module pcdl_top
   import pcdl_pkg::*;
#(
   parameter int NEAR_DEPTH = LOOP_DEPTH
)(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWdata,
   input  wire logic              regWrite,
   input  wire logic              regRead,
   output logic      [DATA_W-1:0] regRdata,
   input  wire pcdl_sym_t         macTx,
   output pcdl_sym_t              macRx,
   input  wire pcdl_sym_t         lineRx,
   output pcdl_sym_t              lineTx,
   output logic                   txPowerUp,
   input  wire logic              mdixStatus,
   input  wire logic              reflectIn,
   output logic                   tdrPulse,
   output logic                   pulseOnRxPair,
   output logic                   forceLinkDown,
   input  wire logic [CODE_W-1:0] matchedLengthCode
);
   // ==========================================================
   // register decode
   function automatic logic regHit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off,
                                   input logic strobe);
      regHit = strobe && (a == off);
   endfunction

   localparam logic [TDR_LEN_W-1:0] LISTEN_LAST = TDR_LEN_W'(TDR_LISTEN_CYC - 1);
   localparam logic [TDR_LEN_W-1:0] PULSE_LAST  = TDR_LEN_W'(TDR_PULSE_CYC - 1);

   logic                  nearLoop_reg,  nearLoop_next;
   logic                  isolate_reg,   isolate_next;
   logic                  farLoop_reg,   farLoop_next;
   logic                  pairSel_reg,   pairSel_next;
   logic                  autoOff_reg,   autoOff_next;
   logic                  tdrDone_reg,   tdrDone_next;
   logic                  tdrEcho_reg,   tdrEcho_next;
   logic [TDR_LEN_W-1:0]  tdrLen_reg,    tdrLen_next;
   logic [TDR_LEN_W-1:0]  cnt_reg,       cnt_next;
   pcdl_tdr_state_t       state_reg,     state_next;
   logic [DATA_W-1:0]     rdata_reg,     rdata_next;
   logic                  reflSync1_reg, reflSync2_reg, reflPrev_reg;
   logic                  reflEdge;
   logic                  crossover;
   logic                  tdrBusy;
   logic [METER_W-1:0]    cableMeters;

   // ==========================================================
   // reflection input synchroniser
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reflSync1_reg <= 1'b0;
         reflSync2_reg <= 1'b0;
         reflPrev_reg  <= 1'b0;
      end else begin
         reflSync1_reg <= reflectIn;
         reflSync2_reg <= reflSync1_reg;
         reflPrev_reg  <= reflSync2_reg;
      end
   end

   assign reflEdge  = reflSync2_reg && !reflPrev_reg;
   assign crossover = autoOff_reg ? pairSel_reg : mdixStatus;
   assign tdrBusy   = (state_reg == PCDL_PULSE) || (state_reg == PCDL_LISTEN);

   // ==========================================================
   // registers and reflectometry sequencer
   always_comb begin
      nearLoop_next = nearLoop_reg;
      isolate_next  = isolate_reg;
      farLoop_next  = farLoop_reg;
      pairSel_next  = pairSel_reg;
      autoOff_next  = autoOff_reg;
      tdrDone_next  = tdrDone_reg;
      tdrEcho_next  = tdrEcho_reg;
      tdrLen_next   = tdrLen_reg;
      cnt_next      = cnt_reg;
      state_next    = state_reg;
      if (regHit(regAddr, REG_CTRL, regWrite)) begin
         nearLoop_next = regWdata[CTRL_LOOP_BIT];
         isolate_next  = regWdata[CTRL_ISO_BIT];
      end
      if (regHit(regAddr, REG_MODE, regWrite)) begin
         farLoop_next = regWdata[MODE_FAR_BIT];
      end
      if (regHit(regAddr, REG_PAIR, regWrite)) begin
         pairSel_next = regWdata[PAIR_SEL_BIT];
         autoOff_next = regWdata[PAIR_AOFF_BIT];
      end
      unique case (state_reg)
         PCDL_IDLE, PCDL_DONE: begin
            if (regHit(regAddr, REG_TDR, regWrite) && regWdata[TDR_EN_BIT]) begin
               state_next   = PCDL_PULSE;
               cnt_next     = '0;
               tdrDone_next = 1'b0;
               tdrEcho_next = 1'b0;
            end
         end
         PCDL_PULSE: begin
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == PULSE_LAST) begin
               state_next = PCDL_LISTEN;
               cnt_next   = '0;
            end
         end
         PCDL_LISTEN: begin
            cnt_next = cnt_reg + 1'b1;
            if (reflEdge) begin
               tdrLen_next  = cnt_reg;
               tdrEcho_next = 1'b1;
               tdrDone_next = 1'b1;
               state_next   = PCDL_DONE;
            end else if (cnt_reg == LISTEN_LAST) begin
               tdrLen_next  = '0;
               tdrDone_next = 1'b1;
               state_next   = PCDL_DONE;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nearLoop_reg <= 1'b0;
         isolate_reg  <= 1'b0;
         farLoop_reg  <= 1'b0;
         pairSel_reg  <= 1'b0;
         autoOff_reg  <= 1'b0;
         tdrDone_reg  <= 1'b0;
         tdrEcho_reg  <= 1'b0;
         tdrLen_reg   <= '0;
         cnt_reg      <= '0;
         state_reg    <= PCDL_IDLE;
      end else begin
         nearLoop_reg <= nearLoop_next;
         isolate_reg  <= isolate_next;
         farLoop_reg  <= farLoop_next;
         pairSel_reg  <= pairSel_next;
         autoOff_reg  <= autoOff_next;
         tdrDone_reg  <= tdrDone_next;
         tdrEcho_reg  <= tdrEcho_next;
         tdrLen_reg   <= tdrLen_next;
         cnt_reg      <= cnt_next;
         state_reg    <= state_next;
      end
   end

   assign tdrPulse      = (state_reg == PCDL_PULSE);
   assign pulseOnRxPair = crossover;
   assign forceLinkDown = tdrBusy;

   // ==========================================================
   // read port
   always_comb begin
      rdata_next = '0;
      if (regRead) begin
         unique case (regAddr)
            REG_CTRL: begin
               rdata_next[CTRL_LOOP_BIT] = nearLoop_reg;
               rdata_next[CTRL_ISO_BIT]  = isolate_reg;
            end
            REG_MODE: begin
               rdata_next[MODE_FAR_BIT] = farLoop_reg;
            end
            REG_PAIR: begin
               rdata_next[PAIR_SEL_BIT]  = pairSel_reg;
               rdata_next[PAIR_AOFF_BIT] = autoOff_reg;
            end
            REG_TDR: begin
               rdata_next[TDR_EN_BIT]                          = tdrBusy;
               rdata_next[TDR_DONE_BIT]                        = tdrDone_reg;
               rdata_next[TDR_ECHO_BIT]                        = tdrEcho_reg;
               rdata_next[TDR_LEN_LSB +: TDR_LEN_W]            = tdrLen_reg;
            end
            REG_CABLE: begin
               rdata_next[CABLE_CODE_LSB +: CODE_W] = matchedLengthCode;
               rdata_next[CABLE_M_LSB +: METER_W]   = cableMeters;
            end
            default: begin
               rdata_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign regRdata = rdata_reg;

   pcdl_len_lut u_len_lut (
      .clk    (clk),
      .rst_n  (rst_n),
      .code   (matchedLengthCode),
      .meters (cableMeters)
   );

   // ==========================================================
   // near-end loop pipeline through coding stages
   pcdl_sym_t stage_reg [NEAR_DEPTH];

   genvar gi;
   generate
      for (gi = 0; gi < NEAR_DEPTH; gi++) begin : g_stage
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage_reg[gi] <= '0;
            end else if (gi == 0) begin
               stage_reg[gi] <= macTx;
            end else begin
               stage_reg[gi] <= stage_reg[(gi == 0) ? 0 : gi - 1];
            end
         end
      end
   endgenerate

   // ==========================================================
   // data path
   pcdl_sym_t macRx_reg,  macRx_next;
   pcdl_sym_t lineTx_reg, lineTx_next;
   logic      txPower_reg, txPower_next;

   always_comb begin
      macRx_next   = '0;
      lineTx_next  = '0;
      txPower_next = !nearLoop_reg;
      if (farLoop_reg) begin
         lineTx_next = lineRx;
         macRx_next  = '0;
      end else if (nearLoop_reg) begin
         macRx_next = isolate_reg ? '0 : stage_reg[NEAR_DEPTH-1];
      end else if (!isolate_reg && !tdrBusy) begin
         lineTx_next = macTx;
         macRx_next  = lineRx;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         macRx_reg   <= '0;
         lineTx_reg  <= '0;
         txPower_reg <= 1'b0;
      end else begin
         macRx_reg   <= macRx_next;
         lineTx_reg  <= lineTx_next;
         txPower_reg <= txPower_next;
      end
   end

   assign macRx     = macRx_reg;
   assign lineTx    = lineTx_reg;
   assign txPowerUp = txPower_reg;

   // ==========================================================
   // checks
   logic nearOnly;
   logic plainPath;
   assign nearOnly  = nearLoop_reg && !farLoop_reg && !isolate_reg;
   assign plainPath = !nearLoop_reg && !farLoop_reg && !isolate_reg && !tdrBusy;

   sequence nearHeld;
      nearOnly [*5];
   endsequence
   sequence farHeld;
      farLoop_reg [*2];
   endsequence
   sequence testStart;
      (state_reg == PCDL_PULSE) && (cnt_reg == '0);
   endsequence

   pulse_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
      tdrPulse && !autoOff_reg |-> (pulseOnRxPair == mdixStatus))
      else $error("pulse pair does not follow crossover state");
   pair_select_a: assert property (@(posedge clk) disable iff (!rst_n)
      tdrPulse && autoOff_reg |-> (pulseOnRxPair == pairSel_reg))
      else $error("pulse pair does not follow manual select");
   tdr_length_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == PCDL_LISTEN) && reflEdge |=> tdrDone_reg && tdrEcho_reg && (tdrLen_reg == $past(cnt_reg)))
      else $error("reflection time not captured");
   tdr_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
      testStart |-> ##[1:260] (state_reg == PCDL_DONE))
      else $error("test did not finish in time");
   link_down_a: assert property (@(posedge clk) disable iff (!rst_n)
      testStart |-> forceLinkDown throughout
         (##[1:256] ((state_reg == PCDL_LISTEN) && (reflEdge || (cnt_reg == LISTEN_LAST)))))
      else $error("link not held down during test");
   near_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
      nearHeld |-> (macRx == $past(macTx, 4)))
      else $error("near loop data mismatch");
   tx_off_a: assert property (@(posedge clk) disable iff (!rst_n)
      nearLoop_reg |=> !txPowerUp)
      else $error("transmitters on in near loop");
   far_echo_a: assert property (@(posedge clk) disable iff (!rst_n)
      farHeld |-> (lineTx == $past(lineRx)))
      else $error("line data not echoed");
   far_iso_a: assert property (@(posedge clk) disable iff (!rst_n)
      farLoop_reg |=> (macRx == '0))
      else $error("controller side not isolated");
   plain_path_a: assert property (@(posedge clk) disable iff (!rst_n)
      plainPath [*2] |-> (lineTx == $past(macTx)) && (macRx == $past(lineRx)))
      else $error("plain path data mismatch");
endmodule // pcdl_top

// ==== dv/pcdl_cable_model.sv ====
`timescale 1ns/1ps
module pcdl_cable_model
   import pcdl_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire pcdl_sym_t  lineTx,
   input  wire logic       tdrPulse,
   input  wire logic       wireBack,
   input  wire logic       echoOn,
   input  wire logic [7:0] echoDelay,
   output pcdl_sym_t       lineRx,
   output logic            reflectIn
);
   // ==========================================================
   // echo timing and partner symbol source
   logic [8:0] age_reg;
   logic       pulse_reg;
   pcdl_sym_t  farSym_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         age_reg    <= 9'h1ff;
         pulse_reg  <= 1'b0;
         farSym_reg <= '0;
      end else begin
         pulse_reg  <= tdrPulse;
         farSym_reg <= '{valid: 1'b1, data: {farSym_reg.data[0], ~farSym_reg.data[1]}};
         if (tdrPulse && !pulse_reg) begin
            age_reg <= 9'h000;
         end else if (age_reg != 9'h1ff) begin
            age_reg <= age_reg + 9'h001;
         end
      end
   end

   // open line echoes after a fixed flight time, matched line never
   assign reflectIn = echoOn && (age_reg >= {1'b0, echoDelay})
                      && (age_reg < {1'b0, echoDelay} + 9'h003);
   // short loop cable wires the transmitter straight back
   assign lineRx = wireBack ? lineTx : farSym_reg;
endmodule // pcdl_cable_model

// ==== dv/tb_phy_cable_diag_loopback.sv ====
`timescale 1ns/1ps
module tb_phy_cable_diag_loopback import pcdl_pkg::*;;
   localparam logic [31:0] PAT      = 32'h1b6e_4c93;
   localparam logic [15:0] PAIRV[4] = '{16'h0000, 16'h0000, 16'ha000, 16'h2000};
   localparam logic        MDIXV[4] = '{1'h0, 1'h1, 1'h0, 1'h1};
   localparam logic        EXPP[4]  = '{1'h0, 1'h1, 1'h1, 1'h0};
   localparam logic [7:0]  DLY[4]   = '{8'h0a, 8'h1e, 8'h00, 8'h32};
   localparam logic [7:0]  MTR[16]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h11, 8'h1b, 8'h26,
                                        8'h31, 8'h3b, 8'h46, 8'h51, 8'h5b, 8'h66, 8'h71, 8'h7b};
   logic              clk;
   logic              rst_n;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata;
   logic              regWrite;
   logic              regRead;
   logic [DATA_W-1:0] regRdata;
   pcdl_sym_t         macTx;
   pcdl_sym_t         macRx;
   pcdl_sym_t         lineRx;
   pcdl_sym_t         lineTx;
   logic              txPowerUp;
   logic              mdixStatus;
   logic              reflectIn;
   logic              tdrPulse;
   logic              pulseOnRxPair;
   logic              forceLinkDown;
   logic [CODE_W-1:0] matchedLengthCode;
   logic              wireBack;
   logic              echoOn;
   logic [7:0]        echoDelay;
   logic [15:0]       st;
   logic [7:0]        len[4];
   int                err_total = 0;
   int                checked = 0;
   int                cycles = 0;

   pcdl_top #(.NEAR_DEPTH(3)) u_dut (
      .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .macTx(macTx), .macRx(macRx), .lineRx(lineRx),
      .lineTx(lineTx), .txPowerUp(txPowerUp), .mdixStatus(mdixStatus), .reflectIn(reflectIn),
      .tdrPulse(tdrPulse), .pulseOnRxPair(pulseOnRxPair), .forceLinkDown(forceLinkDown),
      .matchedLengthCode(matchedLengthCode));

   pcdl_cable_model u_cable (
      .clk(clk), .rst_n(rst_n), .lineTx(lineTx), .tdrPulse(tdrPulse), .wireBack(wireBack),
      .echoOn(echoOn), .echoDelay(echoDelay), .lineRx(lineRx), .reflectIn(reflectIn));

   // ==========================================================
   // clock, watchdog, shared tasks
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_total = err_total + 1;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      d = regRdata;
   endtask

   // symbol stream: macRx and lineTx against delayed history, latency 0 means held at zero
   task automatic stream(input int latM, input int latL, input bit far);
      pcdl_sym_t hm[16];
      pcdl_sym_t hr[16];
      pcdl_sym_t eM;
      pcdl_sym_t eL;
      for (int k = 0; k < 16; k++) begin
         @(posedge clk);
         macTx <= '{valid: 1'b1, data: PAT[2*k +: 2]};
         #1;
         hm[k] = macTx;
         hr[k] = lineRx;
         if (k >= 5) begin
            eM = (latM == 0) ? '0 : hm[k-latM];
            eL = (latL == 0) ? '0 : (far ? hr[k-latL] : hm[k-latL]);
            check("macRx", {13'h0, macRx}, {13'h0, eM});
            check("lineTx", {13'h0, lineTx}, {13'h0, eL});
         end
      end
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst_n = 1'b0;
      regAddr = '0;
      regWdata = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
      macTx = '0;
      mdixStatus = 1'b0;
      matchedLengthCode = '0;
      wireBack = 1'b1;
      echoOn = 1'b0;
      echoDelay = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check("txPowerUp", 16'(txPowerUp), 16'h0001);
      stream(2, 1, 1'b0);
      wr(REG_CTRL, 16'h4000);
      repeat (2) @(posedge clk);
      #1;
      check("txPowerUp", 16'(txPowerUp), 16'h0000);
      stream(4, 0, 1'b0);
      wr(REG_CTRL, 16'h0000);
      wireBack <= 1'b0;
      wr(REG_MODE, 16'h0200);
      stream(0, 1, 1'b1);
      wr(REG_MODE, 16'h0000);
      wireBack <= 1'b1;
      wr(REG_CTRL, 16'h0400);
      stream(0, 0, 1'b0);
      wr(REG_CTRL, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk);
         mdixStatus <= MDIXV[i];
         echoOn     <= (DLY[i] != 8'h00);
         echoDelay  <= DLY[i];
         wr(REG_PAIR, PAIRV[i]);
         wr(REG_TDR, 16'h8000);
         #1;
         check("tdrPulse", 16'(tdrPulse), 16'h0001);
         check("pairSel", 16'(pulseOnRxPair), 16'(EXPP[i]));
         check("linkDown", 16'(forceLinkDown), 16'h0001);
         st = '0;
         for (int n = 0; n < 300 && st[TDR_DONE_BIT] !== 1'b1; n++) begin
            rd(REG_TDR, st);
         end
         check("done", 16'(st[TDR_DONE_BIT]), 16'h0001);
         check("echo", 16'(st[TDR_ECHO_BIT]), 16'(DLY[i] != 8'h00));
         check("linkDown", 16'(forceLinkDown), 16'h0000);
         len[i] = st[TDR_LEN_LSB +: TDR_LEN_W];
      end
      wr(REG_PAIR, 16'h0000);
      check("lenStep", {8'h00, 8'(len[1] - len[0])}, 16'h0014);
      check("lenStep", {8'h00, 8'(len[3] - len[1])}, 16'h0014);
      check("lenNone", {8'h00, len[2]}, 16'h0000);
      for (int c = 0; c < 16; c++) begin
         @(posedge clk);
         matchedLengthCode <= 4'(c);
         repeat (2) @(posedge clk);
         rd(REG_CABLE, st);
         check("cable", st, {4'(c), 4'h0, MTR[c]});
      end
      wr(5'h05, 16'hffff);
      rd(5'h05, st);
      check("unmapped", st, 16'h0000);
      stop_test();
   end
endmodule // tb_phy_cable_diag_loopback
